// *** rtl/rfs_fill_tracker.sv ***
/*
  byte fill tracker: counts bytes put into and taken out of the frame buffer
  and flags a take that overtakes the fill. strobes come from the same clock.
*/
`timescale 1ns/100ps
module rfs_fill_tracker
  import rfs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clrWr,
  input  wire logic             clrRd,
  input  wire logic             wrStb,
  input  wire logic             rdStb,
  output logic [CNT_W-1:0]      wrCnt,
  output logic [CNT_W-1:0]      rdCnt,
  output logic                  underrun
);

  logic [CNT_W-1:0] wrCnt_ff;
  logic [CNT_W-1:0] rdCnt_ff;
  logic             underrun_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n || clrWr)
      wrCnt_ff <= '0;
    else if (wrStb)
      wrCnt_ff <= wrCnt_ff + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || clrRd)
      rdCnt_ff <= '0;
    else if (rdStb)
      rdCnt_ff <= rdCnt_ff + 8'h01;
  end

  // a take with nothing left ahead of it is an underrun
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      underrun_ff <= 1'b0;
    else
      underrun_ff <= rdStb && !clrRd && (rdCnt_ff >= wrCnt_ff);
  end

  assign wrCnt    = wrCnt_ff;
  assign rdCnt    = rdCnt_ff;
  assign underrun = underrun_ff;

  a_underrun_cause: assert property (@(posedge clk) disable iff (!reset_n)
    underrun_ff |-> $past(rdStb) && ($past(rdCnt_ff) >= $past(wrCnt_ff)))
    else $error("underrun flagged without overtaking read");

endmodule : rfs_fill_tracker

// *** rtl/rfs_frame_sequencer.sv ***
/*
  frame sequencer: receive/transmit sequencing around a 128 byte frame buffer.
  assumes an spi decoder on clk delivers host requests as one-cycle strobes,
  and the receive demodulator delivers frame events on clk.
*/
`timescale 1ns/100ps
module rfs_frame_sequencer
  import rfs_pkg::*;
#(
  parameter int unsigned SHR_CYCLES = rfs_pkg::SHR_CYC
)
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               sleepTxTriggerPin,
  input  rfs_pkg::rfs_host_req_t  hostReq,
  input  rfs_pkg::rfs_rx_phy_t    rxPhy,
  input  wire logic [1:0]         phyRateSelect,
  input  wire logic [4:0]         channelSelect,
  input  rfs_pkg::rfs_irq_t       irqEnable,
  output rfs_pkg::rfs_irq_t       irqPulse,
  output rfs_pkg::rfs_state_t     stateRegister,
  output logic                    rxSearch,
  output logic [4:0]              rxChannel,
  output logic [7:0]              rdData,
  output logic                    rdValid,
  output logic                    shrActive,
  output logic [7:0]              txByte,
  output logic                    txByteValid
);
  import rfs_pkg::*;

  function automatic logic [TIMER_W-1:0] bytePeriod(input logic [1:0] sel);
    bytePeriod = TIMER_W'(BYTE_CYC_250K >> sel);
  endfunction : bytePeriod

  rfs_state_t       state_ff;
  logic             extTx_ff;
  logic [2:0]       trigSync_ff;
  logic [TIMER_W-1:0] phaseCnt_ff;
  logic [TIMER_W-1:0] earlyCnt_ff;
  logic             earlyOk_ff;
  logic [7:0]       txLeft_ff;
  logic             txFirst_ff;
  logic [7:0]       buffer [BUF_DEPTH];
  rfs_irq_t         irq_ff;
  logic             rxSearch_ff;
  logic [4:0]       rxChannel_ff;
  logic [7:0]       rdData_ff;
  logic             rdValid_ff;
  logic             shrActive_ff;
  logic [7:0]       txByte_ff;
  logic             txByteValid_ff;

  logic             trigEdge;
  logic             txStartReq;
  logic             txTake;
  logic             txLast;
  logic             hostRd;
  logic [CNT_W-1:0] rxWrCnt, rxRdCnt, txWrCnt, txRdCnt;
  logic             rxUnderrun, txUnderrun;

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin: two flops against metastability, third for the edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      trigSync_ff <= 3'h0;
    else
      trigSync_ff <= {trigSync_ff[1:0], sleepTxTriggerPin};
  end

  assign trigEdge   = trigSync_ff[1] && !trigSync_ff[2];
  assign txStartReq = trigEdge || (hostReq.cmdValid && hostReq.stateCommandField == CMD_TX_START);
  assign txTake     = (state_ff == ST_TX_DATA) && (phaseCnt_ff == '0);
  // last byte is the length byte itself for an empty frame, else the one with one left to go
  assign txLast     = txTake && (txFirst_ff ? (buffer[txRdCnt[ADDR_W-1:0]][LEN_MSB:0] == '0)
                                            : (txLeft_ff == 8'h01));
  // reads during a frame are ignored until the early-read delay is over
  assign hostRd     = hostReq.rdStrobe && (state_ff != ST_RX_BUSY || earlyOk_ff);

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_OFF;
      extTx_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_OFF, ST_RX_LISTEN, ST_PLL_ON:
        begin
          if (state_ff == ST_PLL_ON && txStartReq)
            state_ff <= ST_TX_SETTLE;
          else if (state_ff == ST_RX_LISTEN && rxPhy.frameDetect)
            state_ff <= ST_RX_BUSY;
          else if (hostReq.cmdValid)
          begin
            case (hostReq.stateCommandField)
              CMD_OFF:         state_ff <= ST_OFF;
              CMD_RX_ON, CMD_AUTO_ACK_RX: state_ff <= ST_RX_LISTEN;
              CMD_PLL_ON:      begin state_ff <= ST_PLL_ON; extTx_ff <= 1'b0; end
              CMD_EXT_TX:      begin state_ff <= ST_PLL_ON; extTx_ff <= 1'b1; end
              default:         state_ff <= state_ff;
            endcase
          end
        end
        ST_RX_BUSY:
          if (rxPhy.frameDone)
            state_ff <= ST_RX_LISTEN;
        ST_TX_SETTLE:
          if (phaseCnt_ff == TIMER_W'(SETTLE_CYC - 1))
            state_ff <= ST_TX_SHR;
        ST_TX_SHR:
          if (phaseCnt_ff == TIMER_W'(SHR_CYCLES - 1))
            state_ff <= ST_TX_DATA;
        ST_TX_DATA:
          if (txLast)
            state_ff <= ST_PLL_ON;
        default:
          state_ff <= ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase timer: counts up in settle and header, down per byte on air
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      phaseCnt_ff <= '0;
    else if (state_ff == ST_PLL_ON && txStartReq)
      phaseCnt_ff <= '0;
    else if (state_ff == ST_TX_SETTLE)
      phaseCnt_ff <= (phaseCnt_ff == TIMER_W'(SETTLE_CYC - 1)) ? '0 : phaseCnt_ff + 13'h0001;
    else if (state_ff == ST_TX_SHR)
      phaseCnt_ff <= (phaseCnt_ff == TIMER_W'(SHR_CYCLES - 1)) ? '0 : phaseCnt_ff + 13'h0001;
    else if (state_ff == ST_TX_DATA)
      phaseCnt_ff <= (phaseCnt_ff == '0) ? bytePeriod(phyRateSelect) - 13'h0001 : phaseCnt_ff - 13'h0001;
    else
      phaseCnt_ff <= '0;
  end

  // the first byte taken carries the length of the rest of the frame
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      txFirst_ff <= 1'b1;
      txLeft_ff  <= 8'h00;
    end
    else if (state_ff != ST_TX_DATA)
    begin
      txFirst_ff <= 1'b1;
      txLeft_ff  <= 8'h00;
    end
    else if (txTake)
    begin
      txFirst_ff <= 1'b0;
      txLeft_ff  <= txFirst_ff ? {1'b0, buffer[txRdCnt[ADDR_W-1:0]][LEN_MSB:0]} : txLeft_ff - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // early read delay after a frame is detected
  always_ff @(posedge clk)
  begin
    if (!reset_n || (state_ff == ST_RX_LISTEN && rxPhy.frameDetect))
    begin
      earlyCnt_ff <= '0;
      earlyOk_ff  <= 1'b0;
    end
    else if (state_ff == ST_RX_BUSY && !earlyOk_ff)
    begin
      earlyCnt_ff <= earlyCnt_ff + 13'h0001;
      earlyOk_ff  <= (earlyCnt_ff == TIMER_W'(EARLY_READ_CYC - 2));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame buffer; host fill and radio drain use separate counters so both can overlap
  always_ff @(posedge clk)
  begin
    if (state_ff == ST_RX_BUSY && rxPhy.byteValid)
      buffer[rxWrCnt[ADDR_W-1:0]] <= rxPhy.byteData;
    if (hostReq.wrStrobe)
      buffer[txWrCnt[ADDR_W-1:0]] <= hostReq.wrData;
  end

  rfs_fill_tracker u_rx_fill (
    .clk      (clk),
    .reset_n  (reset_n),
    .clrWr    (state_ff == ST_RX_LISTEN && rxPhy.frameDetect),
    .clrRd    (hostReq.rdBegin || (state_ff == ST_RX_LISTEN && rxPhy.frameDetect)),
    .wrStb    (state_ff == ST_RX_BUSY && rxPhy.byteValid),
    .rdStb    (hostRd),
    .wrCnt    (rxWrCnt),
    .rdCnt    (rxRdCnt),
    .underrun (rxUnderrun)
  );

  rfs_fill_tracker u_tx_fill (
    .clk      (clk),
    .reset_n  (reset_n),
    .clrWr    (hostReq.wrBegin),
    .clrRd    (state_ff == ST_PLL_ON && txStartReq),
    .wrStb    (hostReq.wrStrobe),
    .rdStb    (txTake),
    .wrCnt    (txWrCnt),
    .rdCnt    (txRdCnt),
    .underrun (txUnderrun)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data outputs; header is produced here, the buffer is untouched until data phase
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdData_ff      <= 8'h00;
      rdValid_ff     <= 1'b0;
      txByte_ff      <= 8'h00;
      txByteValid_ff <= 1'b0;
      shrActive_ff   <= 1'b0;
    end
    else
    begin
      rdValid_ff     <= hostRd;
      if (hostRd)
        rdData_ff    <= buffer[rxRdCnt[ADDR_W-1:0]];
      txByteValid_ff <= txTake;
      if (txTake)
        txByte_ff    <= buffer[txRdCnt[ADDR_W-1:0]];
      shrActive_ff   <= (state_ff == ST_TX_SHR);
    end
  end

  // receive search follows the listen state on the chosen channel
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rxSearch_ff  <= 1'b0;
      rxChannel_ff <= 5'h00;
    end
    else
    begin
      rxSearch_ff  <= (state_ff == ST_RX_LISTEN);
      rxChannel_ff <= channelSelect;
    end
  end

  // interrupt pulses, each gated by its enable
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_ff <= '0;
    else
    begin
      irq_ff.frameStart  <= irqEnable.frameStart && state_ff == ST_RX_LISTEN && rxPhy.frameDetect;
      irq_ff.transferEnd <= irqEnable.transferEnd && ((state_ff == ST_RX_BUSY && rxPhy.frameDone)
                            || txLast);
      irq_ff.underrun    <= irqEnable.underrun && (rxUnderrun || txUnderrun);
    end
  end

  assign irqPulse      = irq_ff;
  assign stateRegister = state_ff;
  assign rxSearch      = rxSearch_ff;
  assign rxChannel     = rxChannel_ff;
  assign rdData        = rdData_ff;
  assign rdValid       = rdValid_ff;
  assign shrActive     = shrActive_ff;
  assign txByte        = txByte_ff;
  assign txByteValid   = txByteValid_ff;

  ////////////////////////////////////////////////////////////////////////////
  a_search_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 rxSearch_ff == ($past(state_ff) == ST_RX_LISTEN))
    else $error("receive search does not follow listen state");

  a_frame_start_irq: assert property (@(posedge clk) disable iff (!reset_n)
    irq_ff.frameStart |-> $past(state_ff) == ST_RX_LISTEN && state_ff == ST_RX_BUSY)
    else $error("frame-start without entering reception");

  a_early_read: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_RX_LISTEN && rxPhy.frameDetect) ##1 (state_ff == ST_RX_BUSY)
      |-> !rdValid_ff [*8])
    else $error("received byte released before delay");

  a_tx_entry: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_TX_SETTLE && $past(state_ff) != ST_TX_SETTLE) |-> $past(state_ff) == ST_PLL_ON)
    else $error("transmit started outside pll-on");

  a_settle_len: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_TX_SHR && $past(state_ff) == ST_TX_SETTLE)
      |-> $past(phaseCnt_ff) == TIMER_W'(SETTLE_CYC - 1))
    else $error("settling phase length wrong");

  a_shr_len: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_TX_DATA && $past(state_ff) == ST_TX_SHR)
      |-> $past(phaseCnt_ff) == TIMER_W'(SHR_CYCLES - 1))
    else $error("header phase length wrong");

  a_header_internal: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == ST_TX_SETTLE || state_ff == ST_TX_SHR) |-> ##1 !txByteValid_ff)
    else $error("buffer byte sent during header");

  a_tx_end_irq: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(state_ff) == ST_TX_DATA && state_ff == ST_PLL_ON && $past(irqEnable.transferEnd))
      |-> irq_ff.transferEnd)
    else $error("transmit end without interrupt");

  a_underrun_irq: assert property (@(posedge clk) disable iff (!reset_n)
    (txUnderrun && irqEnable.underrun) |=> irq_ff.underrun)
    else $error("transmit underrun not signalled");

endmodule : rfs_frame_sequencer

// *** rtl/rfs_pkg.sv ***
/*
  shared constants and carrier types for the radio frame sequencer.
  assumes a 40 MHz core clock; all cycle counts derive from that rate.
*/
package rfs_pkg;

  localparam int unsigned CLK_MHZ        = 40;
  // phase durations in microseconds
  localparam int unsigned SETTLE_US      = 16;
  localparam int unsigned SHR_US         = 160;
  localparam int unsigned EARLY_READ_US  = 32;
  localparam int unsigned SETTLE_CYC     = SETTLE_US * CLK_MHZ;
  localparam int unsigned SHR_CYC        = SHR_US * CLK_MHZ;
  localparam int unsigned EARLY_READ_CYC = EARLY_READ_US * CLK_MHZ;
  // one byte on air: 32 us at 250 kb/s, halving per rate step
  localparam int unsigned BYTE_US_250K   = 32;
  localparam int unsigned BYTE_CYC_250K  = BYTE_US_250K * CLK_MHZ;

  localparam int unsigned TIMER_W        = 13;
  localparam int unsigned CNT_W          = 8;
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned BUF_DEPTH      = 128;
  localparam int unsigned LEN_MSB        = 6;

  // state command field encodings
  localparam logic [4:0] CMD_NOP         = 5'h00;
  localparam logic [4:0] CMD_TX_START    = 5'h02;
  localparam logic [4:0] CMD_RX_ON       = 5'h06;
  localparam logic [4:0] CMD_OFF         = 5'h08;
  localparam logic [4:0] CMD_PLL_ON      = 5'h09;
  localparam logic [4:0] CMD_AUTO_ACK_RX = 5'h16;
  localparam logic [4:0] CMD_EXT_TX      = 5'h19;

  typedef enum logic [6:0] {
    ST_OFF       = 7'h01,
    ST_RX_LISTEN = 7'h02,
    ST_RX_BUSY   = 7'h04,
    ST_PLL_ON    = 7'h08,
    ST_TX_SETTLE = 7'h10,
    ST_TX_SHR    = 7'h20,
    ST_TX_DATA   = 7'h40
  } rfs_state_t;

  typedef struct packed {
    logic       cmdValid;
    logic [4:0] stateCommandField;
    logic       wrBegin;
    logic       wrStrobe;
    logic [7:0] wrData;
    logic       rdBegin;
    logic       rdStrobe;
  } rfs_host_req_t;

  typedef struct packed {
    logic       frameDetect;
    logic       byteValid;
    logic [7:0] byteData;
    logic       frameDone;
  } rfs_rx_phy_t;

  typedef struct packed {
    logic frameStart;
    logic transferEnd;
    logic underrun;
  } rfs_irq_t;

endpackage : rfs_pkg

// *** testbench/radio_frame_buffer_sequencing_tb_top.sv ***
/*
  self-checking bench for the frame sequencer: tasks drive host requests,
  results are queued as expected and a watcher compares them as they appear.
  assumes rfs_pkg, the design and the phy model are compiled first.
*/
`timescale 1ns/100ps
module radio_frame_buffer_sequencing_tb_top;
  import rfs_pkg::*;
  localparam int unsigned SHR = 40;
  logic          clk;
  logic          reset_n;
  logic          sleepTxTriggerPin;
  rfs_host_req_t hostReq;
  rfs_rx_phy_t   rxPhy;
  logic [1:0]    phyRateSelect;
  logic [4:0]    channelSelect;
  rfs_irq_t      irqEnable;
  rfs_irq_t      irqPulse;
  rfs_state_t    stateRegister;
  logic          rxSearch;
  logic [4:0]    rxChannel;
  logic [7:0]    rdData;
  logic          rdValid;
  logic          shrActive;
  logic [7:0]    txByte;
  logic          txByteValid;
  logic          phyGo;
  logic [7:0]    phyLen;
  logic [7:0]    phyBase;
  logic [8:0]    qTx[$];
  logic [8:0]    qRd[$];
  int            qIrq[$];
  int            fails;
  int            numChecks;
  int            cyc;

  rfs_frame_sequencer #(.SHR_CYCLES(SHR)) dut
  (
    .clk(clk), .reset_n(reset_n), .sleepTxTriggerPin(sleepTxTriggerPin), .hostReq(hostReq),
    .rxPhy(rxPhy), .phyRateSelect(phyRateSelect), .channelSelect(channelSelect),
    .irqEnable(irqEnable), .irqPulse(irqPulse), .stateRegister(stateRegister), .rxSearch(rxSearch),
    .rxChannel(rxChannel), .rdData(rdData), .rdValid(rdValid), .shrActive(shrActive),
    .txByte(txByte), .txByteValid(txByteValid)
  );
  rfs_rx_phy_model #(.GAP(400)) phy
  (
    .clk(clk), .go(phyGo), .len(phyLen), .base(phyBase), .rxPhy(rxPhy)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d fails=%0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // top bit of an entry marks a byte whose value is stale after underrun
  task automatic popData(ref logic [8:0] q[$], input logic [7:0] seen);
    logic [8:0] e;
    check(16'(q.size() != 0), 16'h1);
    if (q.size() != 0)
    begin
      e = q.pop_front();
      if (!e[8])
        check(16'(seen), 16'(e[7:0]));
    end
  endtask : popData

  task automatic popIrq(input int k);
    int idx[$];
    idx = qIrq.find_first_index(x) with (x == k);
    check(16'(idx.size()), 16'h1);
    if (idx.size() != 0)
      qIrq.delete(idx[0]);
  endtask : popIrq

  task automatic waitDrain(input int lim);
    int n;
    n = 0;
    while ((qTx.size() + qRd.size() + qIrq.size()) != 0 && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
    begin
      fails++;
      stop_test();
    end
  endtask : waitDrain

  task automatic cmd(input logic [4:0] c);
    hostReq.cmdValid = 1'h1;
    hostReq.stateCommandField = c;
    tick(1);
    hostReq.cmdValid = 1'h0;
  endtask : cmd

  task automatic rdByte(input logic [8:0] e);
    qRd.push_back(e);
    hostReq.rdStrobe = 1'h1;
    tick(1);
    hostReq.rdStrobe = 1'h0;
    tick(1);
  endtask : rdByte

  task automatic rdRestart;
    hostReq.rdBegin = 1'h1;
    tick(1);
    hostReq.rdBegin = 1'h0;
  endtask : rdRestart

  // writes the length byte and nData of len payload bytes, gap+2 cycles apart
  task automatic loadFrame(input int len, input int nData, input int gap);
    logic [7:0] d;
    hostReq.wrBegin = 1'h1;
    tick(1);
    hostReq.wrBegin = 1'h0;
    qTx.push_back({1'h0, 8'(len)});
    hostReq.wrStrobe = 1'h1;
    hostReq.wrData = 8'(len);
    tick(1);
    hostReq.wrStrobe = 1'h0;
    for (int i = 0; i < len; i++)
    begin
      d = 8'($urandom);
      qTx.push_back({i >= nData, d});
      if (i < nData)
      begin
        tick(gap + 1);
        hostReq.wrStrobe = 1'h1;
        hostReq.wrData = d;
        tick(1);
        hostReq.wrStrobe = 1'h0;
      end
    end
  endtask : loadFrame

  task automatic rxFrame(input int n);
    phyBase = 8'($urandom);
    phyLen = 8'(n);
    phyGo = 1'h1;
    tick(1);
    phyGo = 1'h0;
  endtask : rxFrame

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (reset_n === 1'h1)
    begin
      if (txByteValid === 1'h1)
        popData(qTx, txByte);
      if (rdValid === 1'h1)
        popData(qRd, rdData);
      for (int k = 0; k < 3; k++)
        if (irqPulse[k] === 1'h1)
          popIrq(k);
    end
  end

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    reset_n = 1'h0;
    hostReq = '0;
    sleepTxTriggerPin = 1'h0;
    irqEnable = 3'h7;
    phyRateSelect = 2'h0;
    channelSelect = 5'h0;
    phyGo = 1'h0;
    phyLen = 8'h0;
    phyBase = 8'h0;
    fails = 0;
    numChecks = 0;
    void'($urandom(93));
    tick(3);
    reset_n = 1'h1;
    cmd(CMD_TX_START);
    tick(2);
    check(16'(stateRegister), 16'(ST_OFF));
    channelSelect = 5'($urandom_range(26, 11));
    cmd(CMD_RX_ON);
    tick(2);
    check(16'(stateRegister), 16'(ST_RX_LISTEN));
    check(16'(rxSearch), 16'h1);
    check(16'(rxChannel), 16'(channelSelect));
    // early read: first read lands before the byte may be served, so no data
    qIrq.push_back(2);
    rxFrame(4);
    waitDrain(20);
    qIrq.push_back(1);
    rdRestart();
    hostReq.rdStrobe = 1'h1;
    tick(1);
    hostReq.rdStrobe = 1'h0;
    tick(1300);
    for (int i = 0; i < 4; i++)
    begin
      rdByte({1'h0, phyBase + 8'(i)});
      tick(498);
    end
    waitDrain(3000);
    // frame-start masked: only completion shows, then a relaxed read
    irqEnable.frameStart = 1'h0;
    qIrq.push_back(1);
    rxFrame(3);
    waitDrain(3000);
    rdRestart();
    for (int i = 0; i < 3; i++)
      rdByte({1'h0, phyBase + 8'(i)});
    waitDrain(20);
    irqEnable.frameStart = 1'h1;
    // write first, then start by command, with the opening phase timed
    cmd(CMD_PLL_ON);
    tick(1);
    check(16'(stateRegister), 16'(ST_PLL_ON));
    phyRateSelect = 2'($urandom);
    loadFrame(3, 3, 0);
    qIrq.push_back(1);
    cmd(CMD_TX_START);
    tick(1);
    check(16'(stateRegister), 16'(ST_TX_SETTLE));
    tick(640);
    check(16'(stateRegister), 16'(ST_TX_SHR));
    tick(1);
    check(16'(shrActive), 16'h1);
    cyc = 642;
    while (txByteValid !== 1'h1 && cyc < 2000)
    begin
      tick(1);
      cyc++;
    end
    check(16'(cyc), 16'(1 + SETTLE_CYC + SHR));
    waitDrain(20000);
    // start by the trigger pin, off the clock phase, then write during settling
    #7 sleepTxTriggerPin = 1'h1;
    #100 sleepTxTriggerPin = 1'h0;
    tick(8);
    check(16'(stateRegister), 16'(ST_TX_SETTLE));
    qIrq.push_back(1);
    loadFrame(5, 5, 20);
    waitDrain(20000);
    // extended-transmit state still accepts the start; short fill underruns
    cmd(CMD_EXT_TX);
    loadFrame(4, 2, 0);
    qIrq.push_back(0);
    qIrq.push_back(0);
    qIrq.push_back(1);
    cmd(CMD_TX_START);
    tick(1);
    check(16'(stateRegister), 16'(ST_TX_SETTLE));
    waitDrain(20000);
    sleepTxTriggerPin = 1'h1;
    cmd(CMD_AUTO_ACK_RX);
    tick(2);
    check(16'(rxSearch), 16'h1);
    check(16'(stateRegister), 16'(ST_RX_LISTEN));
    sleepTxTriggerPin = 1'h0;
    cmd(CMD_OFF);
    tick(20);
    check(16'(stateRegister), 16'(ST_OFF));
    check(16'(qTx.size() + qRd.size() + qIrq.size()), 16'h0);
    stop_test();
  end
endmodule : radio_frame_buffer_sequencing_tb_top

// *** testbench/rfs_rx_phy_model.sv ***
/*
  receive demodulator model: on a go request it reports a frame, then len bytes
  (base, base+1, ...) one every GAP cycles, then frame completion.
  assumes go is driven just after a rising edge of clk.
*/
`timescale 1ns/100ps
module rfs_rx_phy_model
  import rfs_pkg::*;
#(
  parameter int unsigned GAP = 400
)
(
  input  wire logic           clk,
  input  wire logic           go,
  input  wire logic [7:0]     len,
  input  wire logic [7:0]     base,
  output rfs_pkg::rfs_rx_phy_t rxPhy
);
  initial
  begin
    rxPhy = '0;
    forever
    begin
      @(posedge clk);
      if (go === 1'h1)
      begin
        #1 rxPhy.frameDetect = 1'h1;
        @(posedge clk);
        #1 rxPhy.frameDetect = 1'h0;
        for (int i = 0; i < len; i++)
        begin
          repeat (GAP - 1) @(posedge clk);
          #1 rxPhy.byteValid = 1'h1;
          rxPhy.byteData = base + 8'(i);
          @(posedge clk);
          #1 rxPhy.byteValid = 1'h0;
          // stale data is inverted so a late sample never looks right
          rxPhy.byteData = ~rxPhy.byteData;
        end
        repeat (GAP - 1) @(posedge clk);
        #1 rxPhy.frameDone = 1'h1;
        @(posedge clk);
        #1 rxPhy.frameDone = 1'h0;
      end
    end
  end
endmodule : rfs_rx_phy_model
